// file: core/icme_core.sv
// counter engine: wishbone registers, counting element and output
module icme_core
  import icme_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire icme_wb_req_t i_wb,
  output icme_wb_rsp_t o_wb,
  input wire logic i_cnt_clk,
  input wire logic i_gate,
  output logic o_out
);
  icme_state_t r_reg;
  icme_state_t r_next;
  icme_mode_t mode;
  icme_mode_t new_mode;
  logic fall;
  logic rise;
  logic trig;
  logic req;
  logic wr;
  logic done;
  logic [15:0] dec1;
  logic [15:0] dec2;
  logic [15:0] sqr_load;

  assign mode = icme_decode(r_reg.cw[ICME_CW_MODE +: 3]);
  assign new_mode = icme_decode(i_wb.dat[ICME_CW_MODE +: 3]);
  assign fall = r_reg.clk_prev && !i_cnt_clk;
  assign rise = !r_reg.clk_prev && i_cnt_clk;
  assign req = i_wb.cyc && i_wb.stb && !r_reg.ack;
  assign wr = req && i_wb.we && i_wb.sel[0];
  // odd count runs from n-1
  assign sqr_load = {r_reg.hold[15:1], 1'b0};

  icme_gate_sampler u_gate (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_cnt_rise(rise),
    .i_consume(fall),
    .i_gate(i_gate),
    .o_trig(trig)
  );

  icme_decrement u_dec1 (
    .i_val(r_reg.ce),
    .i_bcd(r_reg.cw[ICME_CW_BCD]),
    .i_two(1'b0),
    .o_val(dec1)
  );

  icme_decrement u_dec2 (
    .i_val(r_reg.ce),
    .i_bcd(r_reg.cw[ICME_CW_BCD]),
    .i_two(1'b1),
    .o_val(dec2)
  );

  always_comb
  begin
    r_next = r_reg;
    done = 1'b0;
    r_next.clk_prev = i_cnt_clk;
    r_next.ack = req;
    if (fall)
    begin
      case (mode)
        ICME_M_INT:
        begin
          if (r_reg.load_req)
          begin
            r_next.ce = r_reg.hold;
            r_next.load_req = 1'b0;
            r_next.armed = 1'b1;
          end
          else if (r_reg.armed && i_gate)
          begin
            r_next.ce = dec1;
            if (dec1 == ICME_CNT_ZERO)
            begin
              r_next.out = 1'b1;
            end
          end
        end
        ICME_M_ONE:
        begin
          if (trig && r_reg.have)
          begin
            r_next.ce = r_reg.hold;
            r_next.out = 1'b0;
            r_next.armed = 1'b1;
          end
          else if (r_reg.armed)
          begin
            r_next.ce = dec1;
            if (dec1 == ICME_CNT_ZERO)
            begin
              r_next.out = 1'b1;
              r_next.armed = 1'b0;
            end
          end
        end
        ICME_M_RATE:
        begin
          if (r_reg.have && (trig || (r_reg.load_req && !r_reg.armed)))
          begin
            r_next.ce = r_reg.hold;
            r_next.out = 1'b1;
            r_next.armed = 1'b1;
            r_next.load_req = 1'b0;
          end
          else if (r_reg.armed && i_gate)
          begin
            if (r_reg.ce == ICME_CNT_ONE)
            begin
              r_next.ce = r_reg.hold;
              r_next.out = 1'b1;
              r_next.load_req = 1'b0;
            end
            else
            begin
              r_next.ce = dec1;
              if (dec1 == ICME_CNT_ONE)
              begin
                r_next.out = 1'b0;
              end
            end
          end
        end
        ICME_M_SQR:
        begin
          if (r_reg.have && (trig || (r_reg.load_req && !r_reg.armed)))
          begin
            r_next.ce = sqr_load;
            r_next.out = 1'b1;
            r_next.armed = 1'b1;
            r_next.load_req = 1'b0;
          end
          else if (r_reg.armed && i_gate)
          begin
            if (r_reg.ce == ICME_CNT_TWO)
            begin
              if (r_reg.out && r_reg.hold[0])
              begin
                r_next.ce = ICME_CNT_ZERO;
              end
              else
              begin
                r_next.out = !r_reg.out;
                r_next.ce = sqr_load;
                r_next.load_req = 1'b0;
              end
            end
            else if (r_reg.ce == ICME_CNT_ZERO && r_reg.out && r_reg.hold[0])
            begin
              r_next.out = 1'b0;
              r_next.ce = sqr_load;
              r_next.load_req = 1'b0;
            end
            else
            begin
              r_next.ce = dec2;
            end
          end
        end
        ICME_M_STRB:
        begin
          r_next.out = 1'b1;
          if (r_reg.load_req)
          begin
            r_next.ce = r_reg.hold;
            r_next.load_req = 1'b0;
            r_next.armed = 1'b1;
          end
          else if (r_reg.armed && i_gate)
          begin
            r_next.ce = dec1;
            if (dec1 == ICME_CNT_ZERO)
            begin
              r_next.out = 1'b0;
              r_next.armed = 1'b0;
            end
          end
        end
        default:
        begin
          r_next.out = 1'b1;
        end
      endcase
    end
    if (!i_gate && (mode == ICME_M_RATE || mode == ICME_M_SQR))
    begin
      r_next.out = 1'b1;
    end
    if (wr)
    begin
      if (i_wb.adr == ICME_ADR_CTRL)
      begin
        r_next.cw = i_wb.dat[5:0];
        r_next.out = (new_mode != ICME_M_INT);
        r_next.ce = ICME_CNT_ZERO;
        r_next.armed = 1'b0;
        r_next.load_req = 1'b0;
        r_next.have = 1'b0;
        r_next.msb_next = 1'b0;
      end
      else if (i_wb.adr == ICME_ADR_COUNT)
      begin
        case (r_reg.cw[ICME_CW_RL +: 2])
          ICME_RL_LSB:
          begin
            r_next.hold = {ICME_BYTE_ZERO, i_wb.dat[7:0]};
            done = 1'b1;
          end
          ICME_RL_MSB:
          begin
            r_next.hold = {i_wb.dat[7:0], ICME_BYTE_ZERO};
            done = 1'b1;
          end
          ICME_RL_BOTH:
          begin
            if (!r_reg.msb_next)
            begin
              r_next.hold[7:0] = i_wb.dat[7:0];
              r_next.msb_next = 1'b1;
              if (mode == ICME_M_INT)
              begin
                r_next.armed = 1'b0;
                r_next.out = 1'b0;
              end
            end
            else
            begin
              r_next.hold[15:8] = i_wb.dat[7:0];
              r_next.msb_next = 1'b0;
              done = 1'b1;
            end
          end
          default:
          begin
            done = 1'b0;
          end
        endcase
        if (done)
        begin
          r_next.load_req = 1'b1;
          r_next.have = 1'b1;
          if (mode == ICME_M_INT)
          begin
            r_next.out = 1'b0;
          end
        end
      end
    end
    if (req && !i_wb.we)
    begin
      if (i_wb.adr == ICME_ADR_CTRL)
      begin
        r_next.rdat = {26'h000_0000, r_reg.cw};
      end
      else if (i_wb.adr == ICME_ADR_COUNT)
      begin
        r_next.rdat = {16'h0000, r_reg.hold};
      end
      else if (i_wb.adr == ICME_ADR_STAT)
      begin
        r_next.rdat = ICME_WORD_ZERO;
        r_next.rdat[15:0] = r_reg.ce;
        r_next.rdat[ICME_ST_OUT] = r_reg.out;
        r_next.rdat[ICME_ST_ARMED] = r_reg.armed;
        r_next.rdat[ICME_ST_LOADREQ] = r_reg.load_req;
      end
      else
      begin
        r_next.rdat = ICME_WORD_ZERO;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r_reg <= '0;
      r_reg.cw <= ICME_CW_RESET;
    end
    else if (i_ce)
    begin
      r_reg <= r_next;
    end
  end

  assign o_wb.ack = r_reg.ack;
  assign o_wb.dat = r_reg.rdat;
  assign o_out = r_reg.out;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_ctrl_out_low: assert property (i_ce && wr && i_wb.adr == ICME_ADR_CTRL && new_mode == ICME_M_INT
    |=> !o_out && !r_reg.armed) else $error("mode 0 programming left output high");
  a_zero_gate_hold: assert property (i_ce && fall && mode == ICME_M_INT && !i_gate && !r_reg.load_req
    && !wr |=> $stable(r_reg.ce)) else $error("mode 0 counted with gate low");
  a_zero_load: assert property (i_ce && fall && mode == ICME_M_INT && r_reg.load_req && !wr
    |=> r_reg.ce == $past(r_reg.hold) && r_reg.armed) else $error("mode 0 load wrong");
  a_first_byte: assert property (i_ce && wr && i_wb.adr == ICME_ADR_COUNT && mode == ICME_M_INT
    && r_reg.cw[ICME_CW_RL +: 2] == ICME_RL_BOTH && !r_reg.msb_next
    |=> !o_out && !r_reg.armed) else $error("first byte did not stop count");
  a_one_trig_low: assert property (i_ce && fall && mode == ICME_M_ONE && trig && r_reg.have && !wr
    |=> !o_out ##0 r_reg.ce == $past(r_reg.hold)) else $error("one-shot did not start");
  a_gate_forces_high: assert property (i_ce && !i_gate && (mode == ICME_M_RATE || mode == ICME_M_SQR)
    && !wr |=> o_out) else $error("gate low did not force output high");
  a_strobe_one: assert property (i_ce && fall && mode == ICME_M_STRB && !o_out && !wr
    |=> o_out) else $error("strobe longer than one clock");
  a_sqr_step: assert property (i_ce && fall && mode == ICME_M_SQR && r_reg.armed && i_gate && !trig
    && !wr && !r_reg.cw[ICME_CW_BCD] && r_reg.ce > 16'h0004
    |=> r_reg.ce == $past(r_reg.ce) - 16'h0002) else $error("square wave step not two");
  a_ack_once: assert property (o_wb.ack |=> !o_wb.ack) else $error("ack held two cycles");

  c_zero_terminal: cover property (mode == ICME_M_INT && $rose(o_out));
  c_one_pulse: cover property (mode == ICME_M_ONE && $fell(o_out));
  c_rate_pulse: cover property (mode == ICME_M_RATE && $fell(o_out) ##[1:40] $rose(o_out));
  c_sqr_toggle: cover property (mode == ICME_M_SQR && $fell(o_out) ##[1:40] $rose(o_out));
endmodule

// file: core/icme_pkg.sv
// package: constants, types and mode decode for the interval counter engine
// Summary of operation
// - mode 0 output low on programming, stays low, rises when element hits zero
// - mode 0 gate high counts, gate low pauses, output not touched by gate
// - mode 0 count loads on next falling edge undecremented, output rises after N+1
// - mode 0 first of two bytes stops counting and drops output at once
// - mode 0 count written with gate low still loads on next falling edge
// - mode 1 output high; trigger loads count and gives one N-clock low pulse
// - mode 1 gate low ignored; each gate rise reloads hold value and retriggers
// - mode 1 new count waits for next retrigger, running pulse unchanged
// - mode 2 output low one clock when count reaches 1, reload, period N
// - mode 2 gate low stops counting and forces output high; trigger reloads
// - mode 2 initial count loads on next falling edge, first pulse after N
// - mode 2 rewrite loads on trigger or at period end; host never writes 1
// - mode 3 square wave of period N, high first half, low second half
// - mode 3 gate low stops counting and forces output high; trigger reloads
// - mode 3 rewrite loads on trigger or at end of current half cycle
// - mode 3 even count steps by 2, toggles and reloads on reaching 2
// - mode 3 odd count loads N-1, high (N+1)/2 clocks, low (N-1)/2 clocks
// - mode 4 output high, count runs on write, one-clock low strobe at zero
// - mode 4 gate high counts, gate low pauses, output not touched by gate
// - mode 4 count loads on next falling edge undecremented, strobe after N+1
// - mode 4 first byte ignored; second byte reloads, strobe N+1 clocks later
// - count value zero counts as 65536 clocks in binary, 10000 in decimal, in modes 0 to 4
// - counting is 16-bit binary or four-digit decimal by format bit
// - three-bit mode field; modes 2 and 3 ignore its top bit
package icme_pkg;
  localparam logic [3:0] ICME_ADR_CTRL = 4'h0;
  localparam logic [3:0] ICME_ADR_COUNT = 4'h4;
  localparam logic [3:0] ICME_ADR_STAT = 4'h8;
  localparam int ICME_CW_BCD = 0;
  localparam int ICME_CW_MODE = 1;
  localparam int ICME_CW_RL = 4;
  localparam int ICME_ST_OUT = 16;
  localparam int ICME_ST_ARMED = 17;
  localparam int ICME_ST_LOADREQ = 18;
  localparam logic [1:0] ICME_RL_LSB = 2'h1;
  localparam logic [1:0] ICME_RL_MSB = 2'h2;
  localparam logic [1:0] ICME_RL_BOTH = 2'h3;
  localparam logic [15:0] ICME_CNT_ZERO = 16'h0000;
  localparam logic [15:0] ICME_CNT_ONE = 16'h0001;
  localparam logic [15:0] ICME_CNT_TWO = 16'h0002;
  localparam logic [7:0] ICME_BYTE_ZERO = 8'h00;
  localparam logic [31:0] ICME_WORD_ZERO = 32'h0000_0000;
  localparam logic [5:0] ICME_CW_RESET = 6'h00;
  localparam logic [3:0] ICME_BCD_TEN = 4'hA;
  localparam logic [1:0] ICME_STEP_ONE = 2'h1;
  localparam logic [1:0] ICME_STEP_TWO = 2'h2;
  localparam int ICME_DIGITS = 4;

  typedef enum logic [2:0] {
    ICME_M_INT,
    ICME_M_ONE,
    ICME_M_RATE,
    ICME_M_SQR,
    ICME_M_STRB,
    ICME_M_HW
  } icme_mode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } icme_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } icme_wb_rsp_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [5:0] cw;
    logic [15:0] hold;
    logic [15:0] ce;
    logic out;
    logic load_req;
    logic armed;
    logic have;
    logic msb_next;
    logic clk_prev;
  } icme_state_t;

  typedef struct packed {
    logic gate_s;
    logic pend;
  } icme_gate_t;

  function automatic icme_mode_t icme_decode(input logic [2:0] f);
    icme_mode_t m;
    m = ICME_M_INT;
    if (f[1])
    begin
      m = f[0] ? ICME_M_SQR : ICME_M_RATE;
    end
    else if (f[2])
    begin
      m = f[0] ? ICME_M_HW : ICME_M_STRB;
    end
    else
    begin
      m = f[0] ? ICME_M_ONE : ICME_M_INT;
    end
    return m;
  endfunction
endpackage

// file: core/icme_decrement.sv
// decrement by one or two in binary or four-digit decimal
module icme_decrement
  import icme_pkg::*;
(
  input wire logic [15:0] i_val,
  input wire logic i_bcd,
  input wire logic i_two,
  output logic [15:0] o_val
);
  logic [1:0] amt [0:ICME_DIGITS];
  logic [15:0] dec_val;

  assign amt[0] = i_two ? ICME_STEP_TWO : ICME_STEP_ONE;

  generate
    for (genvar g = 0; g < ICME_DIGITS; g++)
    begin : g_digit
      logic [4:0] diff;
      assign diff = {1'b0, i_val[g*4 +: 4]} - {3'b000, amt[g]};
      assign dec_val[g*4 +: 4] = diff[4] ? (diff[3:0] + ICME_BCD_TEN) : diff[3:0];
      assign amt[g+1] = {1'b0, diff[4]};
    end
  endgenerate

  // wrap from zero gives the 65536 and 10000 counts
  assign o_val = i_bcd ? dec_val : (i_val - {14'h0000, amt[0]});
endmodule

// file: core/icme_gate_sampler.sv
// gate sampler: catches gate rises on counter clock, holds trigger pending
module icme_gate_sampler
  import icme_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cnt_rise,
  input wire logic i_consume,
  input wire logic i_gate,
  output logic o_trig
);
  icme_gate_t r_reg;
  icme_gate_t r_next;
  logic rise;

  always_comb
  begin
    r_next = r_reg;
    rise = i_cnt_rise && i_gate && !r_reg.gate_s;
    if (i_cnt_rise)
    begin
      r_next.gate_s = i_gate;
    end
    r_next.pend = (r_reg.pend && !i_consume) || rise;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r_reg <= '{gate_s: 1'b1, pend: 1'b0};
    end
    else if (i_ce)
    begin
      r_reg <= r_next;
    end
  end

  assign o_trig = r_reg.pend;
endmodule

// file: test/icme_far_model.sv
// far side model: counter clock pin and gate pin source
module icme_far_model
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_gate_lvl,
  output logic o_cnt_clk,
  output logic o_gate
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      div_reg <= 4'h0;
      o_gate <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 4'h1;
      o_gate <= i_gate_lvl;
    end
  end
  // eight system clocks high, then eight low
  assign o_cnt_clk = ~div_reg[3];
endmodule

// file: test/testbench.sv
// testbench: register bus scenarios for counter modes 0 to 4
module testbench
  import icme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst;
  logic ce_lvl;
  logic gate_lvl;
  logic cnt_clk;
  logic gate;
  logic out_pin;
  logic prev;
  int hi;
  int tg;
  int err_total;
  int cmp_count;
  icme_wb_req_t req;
  icme_wb_rsp_t rsp;

  always #10 clk = ~clk;

  icme_core i_icme_core (.i_clk(clk), .i_rst(rst), .i_ce(ce_lvl), .i_wb(req), .o_wb(rsp),
    .i_cnt_clk(cnt_clk), .i_gate(gate), .o_out(out_pin));
  icme_far_model i_icme_far_model (.i_clk(clk), .i_rst(rst), .i_gate_lvl(gate_lvl),
    .o_cnt_clk(cnt_clk), .o_gate(gate));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
    do
    begin
      @(posedge clk);
    end
    while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    chk("ack", 32'h0000_0001, {31'h0000_0000, rsp.ack});
    req <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] rd;
    wb(1'b1, a, {24'h00_0000, d}, rd);
  endtask

  task automatic rs(input string nm, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, a, 32'h0000_0000, rd);
    chk(nm, exp, rd);
  endtask

  task automatic ce(input logic [15:0] exp);
    logic [31:0] rd;
    wb(1'b0, ICME_ADR_STAT, 32'h0000_0000, rd);
    chk("count element", {16'h0000, exp}, {16'h0000, rd[15:0]});
  endtask

  task automatic cfg(input logic [1:0] rl, input logic [2:0] m, input logic bcd);
    wr(ICME_ADR_CTRL, {2'h0, rl, m, bcd});
  endtask

  // n counter falling edges, then let the output settle
  task automatic fl(input int n);
    repeat (n) @(negedge cnt_clk);
    repeat (4) @(posedge clk);
  endtask

  task automatic co(input logic e);
    @(posedge clk);
    chk("out", {31'h0000_0000, e}, {31'h0000_0000, out_pin});
  endtask

  task automatic gt(input logic g);
    @(posedge clk);
    gate_lvl <= g;
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    err_total++;
    $display("watchdog expired");
    close_out();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce_lvl = 1'b1;
    gate_lvl = 1'b1;
    req = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rs("status", ICME_ADR_STAT, 32'h0000_0000);
    rs("unmapped", 4'hC, 32'h0000_0000);
    co(1'b0);
    $display("test reset done");
    fl(1);
    cfg(ICME_RL_BOTH, 3'h0, 1'b0);
    co(1'b0);
    fl(1);
    wr(ICME_ADR_COUNT, 8'h02);
    wr(ICME_ADR_COUNT, 8'h00);
    fl(2);
    co(1'b0);
    fl(1);
    co(1'b1);
    wr(ICME_ADR_COUNT, 8'h02);
    co(1'b0);
    wr(ICME_ADR_COUNT, 8'h00);
    fl(2);
    co(1'b0);
    fl(1);
    co(1'b1);
    cfg(ICME_RL_LSB, 3'h0, 1'b0);
    gt(1'b0);
    wr(ICME_ADR_COUNT, 8'h02);
    fl(3);
    co(1'b0);
    ce(16'h0002);
    gt(1'b1);
    fl(1);
    co(1'b0);
    fl(1);
    co(1'b1);
    fl(1);
    cfg(ICME_RL_BOTH, 3'h0, 1'b1);
    wr(ICME_ADR_COUNT, 8'h10);
    wr(ICME_ADR_COUNT, 8'h00);
    fl(2);
    ce(16'h0009);
    cfg(ICME_RL_LSB, 3'h0, 1'b0);
    wr(ICME_ADR_COUNT, 8'h00);
    fl(2);
    ce(16'hFFFF);
    // clock enable low for two counter periods: nothing may count
    @(posedge clk);
    ce_lvl <= 1'b0;
    repeat (32) @(posedge clk);
    ce_lvl <= 1'b1;
    ce(16'hFFFF);
    $display("test mode0 done");
    fl(1);
    cfg(ICME_RL_LSB, 3'h1, 1'b0);
    co(1'b1);
    wr(ICME_ADR_COUNT, 8'h03);
    fl(2);
    co(1'b1);
    gt(1'b0);
    fl(1);
    gt(1'b1);
    fl(1);
    co(1'b0);
    wr(ICME_ADR_COUNT, 8'h05);
    fl(2);
    co(1'b0);
    fl(1);
    co(1'b1);
    gt(1'b0);
    fl(1);
    co(1'b1);
    gt(1'b1);
    fl(1);
    co(1'b0);
    fl(4);
    co(1'b0);
    fl(1);
    co(1'b1);
    $display("test mode1 done");
    fl(1);
    cfg(ICME_RL_LSB, 3'h6, 1'b0);
    co(1'b1);
    wr(ICME_ADR_COUNT, 8'h03);
    fl(2);
    co(1'b1);
    fl(1);
    co(1'b0);
    fl(2);
    co(1'b1);
    fl(1);
    co(1'b0);
    gt(1'b0);
    fl(0);
    co(1'b1);
    fl(1);
    gt(1'b1);
    fl(1);
    ce(16'h0003);
    fl(1);
    co(1'b1);
    fl(1);
    co(1'b0);
    $display("test mode2 done");
    for (int k = 4; k < 6; k++)
    begin
      fl(1);
      cfg(ICME_RL_LSB, k[0] ? 3'h7 : 3'h3, 1'b0);
      wr(ICME_ADR_COUNT, k[7:0]);
      fl(3);
      hi = 0;
      tg = 0;
      prev = out_pin;
      repeat (2 * k)
      begin
        fl(1);
        hi += int'(out_pin);
        tg += int'(out_pin !== prev);
        prev = out_pin;
      end
      chk("high clocks", 2 * ((k + 1) / 2), hi);
      chk("level changes", 32'h0000_0004, tg);
    end
    for (int j = 0; j < 6 && out_pin !== 1'b0; j++)
      fl(1);
    gt(1'b0);
    fl(0);
    co(1'b1);
    fl(1);
    gt(1'b1);
    fl(2);
    co(1'b1);
    $display("test mode3 done");
    fl(1);
    cfg(ICME_RL_BOTH, 3'h4, 1'b0);
    co(1'b1);
    wr(ICME_ADR_COUNT, 8'h03);
    wr(ICME_ADR_COUNT, 8'h00);
    fl(2);
    wr(ICME_ADR_COUNT, 8'h04);
    fl(1);
    co(1'b1);
    fl(1);
    co(1'b0);
    fl(1);
    co(1'b1);
    wr(ICME_ADR_COUNT, 8'h00);
    fl(1);
    gt(1'b0);
    fl(3);
    co(1'b1);
    gt(1'b1);
    fl(3);
    co(1'b1);
    fl(1);
    co(1'b0);
    rs("hold", ICME_ADR_COUNT, 32'h0000_0004);
    $display("test mode4 done");
    close_out();
  end
endmodule
